//--- design/pmc_top.sv
// E1 performance monitor: nine event counters, indirect readback,
// overflow flags and interrupt, APB slave.
// Assumes event pulses are one-cycle, synchronous to core_clk_in.
`timescale 1ns/10ps
`default_nettype none
module pmc_top #(
   parameter int REPORT_TICKS = pmc_pkg::REPORT_CYCLES
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic rstn_in,
   // APB slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Event pulses from decoder, framer, checkers
   input wire logic line_code_violation_in,
   input wire logic framing_error_in,
   input wire logic crc4_error_in,
   input wire logic far_end_block_error_in,
   input wire logic alignment_change_in,
   input wire logic sync_loss_in,
   input wire logic pattern_error_in,
   input wire logic nt_far_end_block_error_in,
   input wire logic nt_crc_error_in,
   // Interrupt
   output logic irq_out
);
   import pmc_pkg::*;

   // ==========================================
   // Reset synchroniser
   logic rst_meta_n_q; // First stage
   logic rst_n_q; // Synchronised reset

   // Async assert, clocked release
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_meta_n_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_n_q <= 1'b1;
         rst_n_q <= rst_meta_n_q;
      end
   end

   // ==========================================
   // Signals
   pmc_state_t s_q; // Registered state
   pmc_state_t s_d; // Next state
   logic [NUM_CNT-1:0] ev; // Event vector
   logic setup; // APB setup phase
   logic wr; // APB write access
   logic [9:0] idx; // Register index
   logic tick; // One-second pulse
   logic manual_rise; // Trigger 0 to 1
   logic report; // Copy-and-clear
   logic [NUM_CNT-1:0] ovf; // Overflow this cycle
   logic [NUM_CNT-1:0] clr; // Flag clear mask
   logic [3:0] csel; // Selected counter
   logic [15:0] cval; // Selected counter value

   // Event vector in counter order
   assign ev = {nt_crc_error_in, nt_far_end_block_error_in, pattern_error_in,
                sync_loss_in, alignment_change_in, far_end_block_error_in,
                crc4_error_in, framing_error_in, line_code_violation_in};

   // ==========================================
   // Next-state logic
   always_comb begin
      s_d = s_q;
      setup = psel_in && !penable_in;
      // Unaligned writes are refused and must leave every register untouched
      wr = psel_in && penable_in && pwrite_in && (paddr_in[1:0] == 2'h0);
      idx = paddr_in[11:2];
      ovf = ZERO_VEC;
      clr = ZERO_VEC;

      // Free-running second divider
      if (s_q.div == DIV_W'(REPORT_TICKS - 1)) begin // see [R17]
         s_d.div = '0;
      end else begin
         s_d.div = s_q.div + DIV_W'(1);
      end
      tick = s_q.auto_en && (s_q.div == DIV_W'(REPORT_TICKS - 1)); // see [R3]

      // Rising edge of manual trigger on a control write
      manual_rise = wr && (idx == IDX_CONTROL) && pwdata_in[CTRL_TRIG_BIT]
                    && !s_q.trig; // see [R4]
      report = tick || manual_rise;

      // Byte of the selected counter
      csel = IDX_CNT[s_q.sel]; // see [R2]
      cval = s_q.cnt[csel];
      if (IDX_HI[s_q.sel]) begin // see [R16]
         cval = {8'h00, cval[15:8]};
      end

      // Copy to readback
      if (report) begin
         s_d.rdbk = cval[7:0]; // see [R3] see [R4]
      end

      // Counters; widths fixed by wrap values
      for (int i = 0; i < NUM_CNT; i++) begin // see [R7] see [R8] see [R9]
         if (report) begin // see [R10] see [R11] see [R12] see [R13]
            // Group clear, keep a coincident event
            s_d.cnt[i] = ev[i] ? CNT_ONE : CNT_ZERO; // see [R5] see [R6]
         end else if (ev[i]) begin // see [R14] see [R15]
            if (s_q.cnt[i] == CNT_MAX[i]) begin
               s_d.cnt[i] = CNT_ZERO;
               ovf[i] = 1'b1; // see [R1]
            end else begin
               s_d.cnt[i] = s_q.cnt[i] + CNT_ONE;
            end
         end
      end

      // APB writes
      if (wr) begin
         unique case (idx)
            IDX_SELECT: s_d.sel = pwdata_in[3:0]; // see [R2]
            IDX_CONTROL: begin
               s_d.trig = pwdata_in[CTRL_TRIG_BIT];
               s_d.auto_en = pwdata_in[CTRL_AUTO_BIT];
            end
            IDX_EN_LOW: s_d.en[NUM_CNT-1:1] = pwdata_in[7:0];
            IDX_EN_HIGH: s_d.en[CNT_LINE] = pwdata_in[0];
            IDX_FLAGS_LOW: clr[NUM_CNT-1:1] = pwdata_in[7:0];
            IDX_FLAGS_HIGH: clr[CNT_LINE] = pwdata_in[0];
            default: begin
               // Read-only or unmapped: no effect
            end
         endcase
      end

      // Sticky flags, set wins over clear
      s_d.flags = (s_q.flags & ~clr) | ovf; // see [R1]
      s_d.irq = |(s_d.flags & s_d.en); // see [R1]

      // Read data and error captured in setup phase
      if (setup) begin
         s_d.slverr = 1'b0;
         s_d.prdata = 32'h0000_0000;
         if (paddr_in[1:0] != 2'h0) begin
            s_d.slverr = 1'b1;
         end else begin
            unique case (idx)
               IDX_SELECT: s_d.prdata[3:0] = s_q.sel;
               IDX_READBACK: s_d.prdata[7:0] = s_q.rdbk;
               IDX_CONTROL: begin
                  s_d.prdata[CTRL_TRIG_BIT] = s_q.trig;
                  s_d.prdata[CTRL_AUTO_BIT] = s_q.auto_en;
               end
               IDX_EN_LOW: s_d.prdata[7:0] = s_q.en[NUM_CNT-1:1];
               IDX_EN_HIGH: s_d.prdata[0] = s_q.en[CNT_LINE];
               IDX_FLAGS_LOW: s_d.prdata[7:0] = s_q.flags[NUM_CNT-1:1];
               IDX_FLAGS_HIGH: s_d.prdata[0] = s_q.flags[CNT_LINE];
               default: s_d.slverr = 1'b1; // Unmapped
            endcase
         end
      end
   end

   // ==========================================
   // State register; reset clears divider and counters
   always_ff @(posedge core_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         s_q <= '0; // see [R17]
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================
   // Outputs
   assign prdata_out = s_q.prdata;
   assign pslverr_out = s_q.slverr && psel_in && penable_in;
   assign pready_out = 1'b1; // Zero wait states
   assign irq_out = s_q.irq;

endmodule // pmc_top
`default_nettype wire

//--- design/pmc_pkg.sv
// Constants, register map and state type of the performance monitor.
// Assumes one 250 MHz system clock and an APB register bus.
// Contract
// [R1] Overflow sets flag; irq only when enabled
// [R2] Counters reached indirectly through 4-bit select
// [R3] Auto-report copies selected counter every second
// [R4] Manual trigger rising edge copies at once
// [R5] Each copy clears all counters together
// [R6] Events during copy-and-clear are still counted
// [R7] 16-bit line code violation counter, indices 09/08
// [R8] 12-bit framing error counter, indices 03/02
// [R9] 10-bit CRC-4 error counter, indices 01/00
// [R10] 10-bit far end block counter, indices 0D/0C
// [R11] 3-bit alignment change counter, index 04
// [R12] 5-bit sync loss counter, index 05
// [R13] 16-bit pattern receiver counter, indices 07/06
// [R14] 10-bit NT far end counter, indices 0F/0E
// [R15] 10-bit NT CRC counter, indices 0B/0A
// [R16] Low byte at lower index, high zero-filled
// [R17] Free-running second divider, reset clears all
package pmc_pkg;

   // ==========================================
   // Register indices (byte address = 4 x index)
   localparam logic [9:0] IDX_SELECT = 10'h00E;
   localparam logic [9:0] IDX_READBACK = 10'h00F;
   localparam logic [9:0] IDX_CONTROL = 10'h0C2;
   localparam logic [9:0] IDX_EN_LOW = 10'h0C3;
   localparam logic [9:0] IDX_EN_HIGH = 10'h0C4;
   localparam logic [9:0] IDX_FLAGS_LOW = 10'h0C5;
   localparam logic [9:0] IDX_FLAGS_HIGH = 10'h0C6;

   // ==========================================
   // Control register fields
   localparam int CTRL_TRIG_BIT = 0;
   localparam int CTRL_AUTO_BIT = 1;

   // ==========================================
   // Counter numbering and limits
   localparam int NUM_CNT = 9;
   localparam int CNT_LINE = 0;
   localparam logic [NUM_CNT-1:0] ZERO_VEC = 9'h000;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   // Wrap values: line, framing, crc4, far end, align, sync, pattern, nt fe, nt crc
   localparam logic [15:0] CNT_MAX [NUM_CNT] = '{16'hFFFF, 16'h0FFF, 16'h03FF, 16'h03FF,
      16'h0007, 16'h001F, 16'hFFFF, 16'h03FF, 16'h03FF};
   // Indirect index to counter number
   localparam logic [3:0] IDX_CNT [16] = '{4'h2, 4'h2, 4'h1, 4'h1, 4'h4, 4'h5, 4'h6,
      4'h6, 4'h0, 4'h0, 4'h8, 4'h8, 4'h3, 4'h3, 4'h7, 4'h7};
   // Indirect indices that read the high byte
   localparam logic [15:0] IDX_HI = 16'hAA8A;

   // ==========================================
   // Timing
   localparam int REPORT_PERIOD_S = 1;
   localparam int CLK_FREQ_HZ = 250000000;
   localparam int REPORT_CYCLES = REPORT_PERIOD_S * CLK_FREQ_HZ;
   localparam int DIV_W = 28;

   // ==========================================
   // Complete module state
   typedef struct packed {
      logic [3:0] sel;
      logic [7:0] rdbk;
      logic auto_en;
      logic trig;
      logic [NUM_CNT-1:0] en;
      logic [NUM_CNT-1:0] flags;
      logic [NUM_CNT-1:0][15:0] cnt;
      logic [DIV_W-1:0] div;
      logic [31:0] prdata;
      logic slverr;
      logic irq;
   } pmc_state_t;

endpackage

//--- test/pmc_checker.sv
// Checker: bus and interrupt relations at the monitor's ports.
// Assumes it is bound into pmc_top.
`timescale 1ns/10ps
`default_nettype none
module pmc_checker import pmc_pkg::*; (
   input wire logic core_clk_in, rstn_in, psel_in, penable_in, pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] prdata_out,
   input wire logic pready_out, pslverr_out, irq_out
);
   wire logic acc = psel_in && penable_in;
   wire logic wr = acc && pwrite_in;
   wire logic mapped = paddr_in[11:2] inside {IDX_SELECT, IDX_READBACK, IDX_CONTROL,
      IDX_EN_LOW, IDX_EN_HIGH, IDX_FLAGS_LOW, IDX_FLAGS_HIGH};
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   property p_rdy; pready_out; endproperty
   a_rdy: assert property (p_rdy) else $error("ready low");
   property p_err_acc; pslverr_out |-> acc; endproperty
   a_err_acc: assert property (p_err_acc) else $error("error outside access");
   property p_unal; acc && paddr_in[1:0] != 2'h0 |-> pslverr_out; endproperty
   a_unal: assert property (p_unal) else $error("unaligned accepted");
   property p_unmap; acc && !mapped |-> pslverr_out; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped accepted");
   property p_map; acc && mapped && paddr_in[1:0] == 2'h0 |-> !pslverr_out; endproperty
   a_map: assert property (p_map) else $error("mapped refused");
   property p_hi0; acc && !pwrite_in |-> prdata_out[31:8] == 24'h0; endproperty
   a_hi0: assert property (p_hi0) else $error("upper read bits set");
   property p_hold; !psel_in |=> $stable(prdata_out); endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   property p_irq_fall; $fell(irq_out) |-> $past(wr, 1) || $past(wr, 2); endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
endmodule // pmc_checker
bind pmc_top pmc_checker u_chk (.*);
`default_nettype wire

//--- test/pmc_evt_src.sv
// Partner: event pulse sources of framer and decoder.
// Assumes burst is called just after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module pmc_evt_src (
   input wire logic clk_in,
   output logic [8:0] ev_out
);
   initial ev_out = 9'h000;
   // Back-to-back one-cycle pulses on one source
   task automatic burst(input int k, input int n);
      repeat (n) begin
         ev_out[k] <= 1'b1;
         @(posedge clk_in);
      end
      ev_out[k] <= 1'b0;
   endtask
endmodule // pmc_evt_src
`default_nettype wire

//--- test/testbench.sv
// Testbench: register tests of the performance monitor.
// Assumes a shortened report period of TICKS cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import pmc_pkg::*;
   localparam int TICKS = 50;
   localparam logic [3:0] LOIDX [9] = '{4'h2, 4'h0, 4'hC, 4'h4, 4'h5, 4'h6, 4'hE, 4'hA, 4'h8};
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] pa = 12'h000;
   logic [31:0] pwd = 32'h0, prd, rdat;
   logic rdy, err, rerr, irq;
   logic [8:0] ev;
   int n_mismatch = 0, cmp_count = 0;
   always #2 clk = ~clk;
   pmc_evt_src evs (.clk_in(clk), .ev_out(ev));
   pmc_top #(.REPORT_TICKS(TICKS)) dut (.core_clk_in(clk), .rstn_in(rstn), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
      .pready_out(rdy), .pslverr_out(err), .framing_error_in(ev[0]), .crc4_error_in(ev[1]),
      .far_end_block_error_in(ev[2]), .alignment_change_in(ev[3]), .sync_loss_in(ev[4]),
      .pattern_error_in(ev[5]), .nt_far_end_block_error_in(ev[6]), .nt_crc_error_in(ev[7]),
      .line_code_violation_in(ev[8]), .irq_out(irq));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // One bus transfer: setup, access until ready, release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rdat = prd;
      rerr = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [9:0] i, input logic [31:0] d);
      apb(1'b1, {i, 2'h0}, d);
   endtask
   task automatic rd(input logic [9:0] i, input logic [31:0] e);
      apb(1'b0, {i, 2'h0}, 32'h0);
      chk(rdat, e);
   endtask
   // Manual report of one indirect index, then read it
   task automatic rep(input logic [3:0] i, input logic [31:0] e);
      wr(IDX_SELECT, {28'h0, i});
      wr(IDX_CONTROL, 32'h1);
      wr(IDX_CONTROL, 32'h0);
      rd(IDX_READBACK, e);
   endtask
   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      wr(IDX_SELECT, 32'h5);
      rd(IDX_SELECT, 32'h5);
      apb(1'b0, 12'h040, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      apb(1'b1, 12'h039, 32'h0);
      chk({31'h0, rerr}, 32'h1);
      rd(IDX_SELECT, 32'h5);
      apb(1'b1, {IDX_READBACK, 2'h0}, 32'hFF);
      chk({31'h0, rerr}, 32'h0);
      $display("test 1 done");
      for (int k = 0; k < 9; k++) begin
         evs.burst(k, k + 2);
         evs.burst((k + 1) % 9, 1);
         rep(LOIDX[k], 32'(k + 2));
         rep(LOIDX[(k + 1) % 9], 32'h0);
      end
      $display("test 2 done");
      evs.burst(5, 300);
      rep(4'h6, 32'h2C);
      evs.burst(5, 300);
      rep(4'h7, 32'h1);
      $display("test 3 done");
      wr(IDX_EN_LOW, 32'h8);
      evs.burst(3, 8);
      rd(IDX_FLAGS_LOW, 32'h8);
      chk({31'h0, irq}, 32'h1);
      wr(IDX_EN_LOW, 32'h0);
      rd(IDX_FLAGS_LOW, 32'h8);
      chk({31'h0, irq}, 32'h0);
      wr(IDX_EN_LOW, 32'h8);
      wr(IDX_FLAGS_LOW, 32'h8);
      rd(IDX_FLAGS_LOW, 32'h0);
      chk({31'h0, irq}, 32'h0);
      rep(4'h4, 32'h0);
      $display("test 4 done");
      wr(IDX_SELECT, 32'h0);
      wr(IDX_CONTROL, 32'h2);
      fork
         evs.burst(1, 120);
         begin
            repeat (110) @(posedge clk);
            rd(IDX_READBACK, 32'(TICKS));
         end
      join
      wr(IDX_CONTROL, 32'h0);
      $display("test 5 done");
      finish_test;
   end
   // Watchdog against a hung transfer
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      finish_test;
   end
endmodule // testbench
`default_nettype wire
